// *** src/sws_pkg.sv ***
// Constants and types shared by the supply supervisor watchdog
package sws_pkg;

  // ****************************************
  // Clock and time base
  // ****************************************
  localparam logic [31:0] CLK_PERIOD_NS = 32'h0000000a;
  // Time base tick of 1 ms
  localparam logic [31:0] TICK_PERIOD_NS = 32'h000f4240;
  localparam logic [31:0] TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // ****************************************
  // Strobe pulse recognition
  // ****************************************
  localparam logic [31:0] STROBE_MIN_PULSE_NS = 32'h00000032;
  // Least pulse in clock cycles, rounded up
  localparam logic [31:0] STROBE_MIN_PULSE_CYCLES =
    (STROBE_MIN_PULSE_NS + CLK_PERIOD_NS - 32'h00000001) / CLK_PERIOD_NS;

  // ****************************************
  // Supervisor periods
  // ****************************************
  // Watchdog timeout period 1600 ms
  localparam logic [31:0] WATCHDOG_TIMEOUT_MS = 32'h00000640;
  // Reset hold period 140 ms
  localparam logic [31:0] RESET_HOLD_MS = 32'h0000008c;
  // Periods in time base ticks
  localparam logic [31:0] WATCHDOG_TIMEOUT_TICKS = (WATCHDOG_TIMEOUT_MS * 32'h000f4240) / TICK_PERIOD_NS;
  localparam logic [31:0] RESET_HOLD_TICKS = (RESET_HOLD_MS * 32'h000f4240) / TICK_PERIOD_NS;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] COUNT_RESET = 32'h00000000;
  localparam logic RESET_N_RESET = 1'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_UNDERVOLT = 2'h0,
    ST_HOLD = 2'h1,
    ST_RUN = 2'h2
  } sws_state_type;

  // Pin levels that are synchronised together
  typedef struct packed {
    logic undervoltage;
    logic strobe;
    logic floating;
  } sws_pins_type;

  localparam sws_pins_type PINS_RESET = '{undervoltage: 1'h1, strobe: 1'h0, floating: 1'h0};

endpackage

// *** src/sws_supervisor.sv ***
// Supply supervisor with watchdog that drives an active-low processor reset
`timescale 1ns/100ps

// What this block does
// - Reset output stays low while the undervoltage indication is present.
// - After undervoltage clears, reset stays low for the hold period.
// - Every rising and falling strobe edge clears the watchdog counter.
// - Strobe pulses as short as 50 ns count as valid edges.
// - Watchdog timeout without strobe edge asserts reset, then hold period applies.
// - Undervoltage reset also clears the watchdog counter.
// - Watchdog counter held at zero while reset is asserted.
// - Floating strobe input disconnects the watchdog from the reset logic.
// - Strobe constantly low or high for the whole timeout causes reset.

module sws_supervisor
  import sws_pkg::*;
#(
  parameter logic [31:0] TICK_LEN = TICK_CYCLES,
  parameter logic [31:0] WATCHDOG_LEN = WATCHDOG_TIMEOUT_TICKS,
  parameter logic [31:0] HOLD_LEN = RESET_HOLD_TICKS
) (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic undervoltage, // Supply below supply_trip_threshold, async pin
  input wire logic watchdog_strobe_input, // Strobe from processor, async pin
  input wire logic strobe_floating, // Window comparator sees strobe floating, async pin
  output logic processor_reset_n, // Reset to processor, active low
  output logic watchdog_running // Watchdog counting, from flip-flop
);

  // ****************************************
  // Count decoding
  // ****************************************
  // High on the last step of a period of len steps
  function automatic logic at_last(input logic [31:0] count, input logic [31:0] len);
    at_last = (count >= len - 32'h00000001);
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  sws_pins_type pins_meta;
  sws_pins_type pins_sync;
  sws_pins_type next_pins_meta;
  sws_pins_type next_pins_sync;

  always_comb begin
    next_pins_meta.undervoltage = undervoltage;
    next_pins_meta.strobe = watchdog_strobe_input;
    next_pins_meta.floating = strobe_floating;
    next_pins_sync = pins_meta;
    if (sys_rst) begin
      next_pins_meta = PINS_RESET;
      next_pins_sync = PINS_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    pins_meta <= next_pins_meta;
    pins_sync <= next_pins_sync;
  end

  // ****************************************
  // Strobe edge detector
  // ****************************************
  logic strobe_prev;
  logic next_strobe_prev;
  logic strobe_edge;

  // Preset matches the synchroniser, so reset itself makes no edge
  always_comb begin
    next_strobe_prev = pins_sync.strobe;
    if (sys_rst) begin
      next_strobe_prev = PINS_RESET.strobe;
    end
  end

  always_ff @(posedge ref_clk) begin
    strobe_prev <= next_strobe_prev;
  end

  // Sampled every cycle, so any pulse of STROBE_MIN_PULSE_CYCLES or more is seen
  assign strobe_edge = (pins_sync.strobe != strobe_prev) && !pins_sync.floating;

  // ****************************************
  // Free-running time base
  // ****************************************
  logic [31:0] tick_count;
  logic [31:0] next_tick_count;
  logic tick;
  logic next_tick;

  always_comb begin
    next_tick_count = tick_count + 32'h00000001;
    next_tick = 1'h0;
    if (at_last(tick_count, TICK_LEN)) begin
      next_tick_count = COUNT_RESET;
      next_tick = 1'h1;
    end
    if (sys_rst) begin
      next_tick_count = COUNT_RESET;
      next_tick = 1'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    tick_count <= next_tick_count;
    tick <= next_tick;
  end

  // ****************************************
  // Supervisor state and counters
  // ****************************************
  sws_state_type state;
  sws_state_type next_state;
  logic [31:0] wd_count;
  logic [31:0] next_wd_count;
  logic [31:0] hold_count;
  logic [31:0] next_hold_count;
  logic next_processor_reset_n;
  logic next_watchdog_running;
  logic wd_expire;

  // Timeout only counts when the strobe pin is driven
  assign wd_expire = tick && !strobe_edge && !pins_sync.floating
                     && at_last(wd_count, WATCHDOG_LEN);

  always_comb begin
    next_state = state;
    case (state)
      ST_UNDERVOLT: begin
        if (!pins_sync.undervoltage) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (pins_sync.undervoltage) begin
          next_state = ST_UNDERVOLT;
        end else if (tick && at_last(hold_count, HOLD_LEN)) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (pins_sync.undervoltage) begin
          next_state = ST_UNDERVOLT;
        end else if (wd_expire) begin
          next_state = ST_HOLD;
        end
      end
      default: begin
        next_state = ST_UNDERVOLT;
      end
    endcase
    // Power-up starts in reset with counters clear
    if (sys_rst) begin
      next_state = ST_UNDERVOLT;
    end
  end

  always_ff @(posedge ref_clk) begin
    state <= next_state;
  end

  // ****************************************
  // Watchdog counter
  // ****************************************
  // Cleared outside the run state, so it only counts while reset is released
  always_comb begin
    next_wd_count = wd_count;
    if (state != ST_RUN || pins_sync.undervoltage) begin
      next_wd_count = COUNT_RESET;
    end else if (strobe_edge || pins_sync.floating) begin
      next_wd_count = COUNT_RESET;
    end else if (wd_expire) begin
      next_wd_count = COUNT_RESET;
    end else if (tick) begin
      next_wd_count = wd_count + 32'h00000001;
    end
    if (sys_rst) begin
      next_wd_count = COUNT_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    wd_count <= next_wd_count;
  end

  // ****************************************
  // Reset hold counter
  // ****************************************
  always_comb begin
    next_hold_count = hold_count;
    if (state != ST_HOLD || pins_sync.undervoltage) begin
      next_hold_count = COUNT_RESET;
    end else if (tick) begin
      if (at_last(hold_count, HOLD_LEN)) begin
        next_hold_count = COUNT_RESET;
      end else begin
        next_hold_count = hold_count + 32'h00000001;
      end
    end
    if (sys_rst) begin
      next_hold_count = COUNT_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    hold_count <= next_hold_count;
  end

  // ****************************************
  // Output registers
  // ****************************************
  // Outputs follow the next state, so they change on the same edge as it
  always_comb begin
    next_processor_reset_n = (next_state == ST_RUN);
    next_watchdog_running = (next_state == ST_RUN) && !pins_sync.floating;
    if (sys_rst) begin
      next_processor_reset_n = RESET_N_RESET;
      next_watchdog_running = 1'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    processor_reset_n <= next_processor_reset_n;
    watchdog_running <= next_watchdog_running;
  end

endmodule

// *** verification/sws_checker.sv ***
// Assertion checker for the supply supervisor watchdog
`timescale 1ns/100ps
module sws_checker #(
  parameter logic [31:0] TICK_LEN = 32'h00000004,
  parameter logic [31:0] WATCHDOG_LEN = 32'h00000014,
  parameter logic [31:0] HOLD_LEN = 32'h00000005
) (
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic undervoltage, // Supply low
  input wire logic watchdog_strobe_input, // Strobe pin
  input wire logic strobe_floating, // Strobe released
  input wire logic processor_reset_n, // Reset out
  input wire logic watchdog_running // Counting
);
  localparam int TMO_MAX = int'(WATCHDOG_LEN * TICK_LEN) + 8;
  localparam int TMO_MIN = int'((WATCHDOG_LEN - 1) * TICK_LEN);
  int idle_cnt;
  int next_idle_cnt;
  logic last_strobe;
  always_comb begin
    next_idle_cnt = idle_cnt + 1;
    if (sys_rst || !watchdog_running || strobe_floating || watchdog_strobe_input != last_strobe)
      next_idle_cnt = 0;
  end
  always_ff @(posedge ref_clk) begin
    idle_cnt <= next_idle_cnt;
    last_strobe <= watchdog_strobe_input;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_uv; $past(undervoltage, 4) |-> !processor_reset_n; endproperty
  a_uv: assert property (p_uv) else $error("reset high under undervoltage");
  property p_hold; $fell(undervoltage) |=> !processor_reset_n [*8]; endproperty
  a_hold: assert property (p_hold) else $error("reset released without hold");
  property p_tmo; idle_cnt <= TMO_MAX; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout missed");
  property p_early; $fell(processor_reset_n) |-> $past(undervoltage, 3) || idle_cnt >= TMO_MIN; endproperty
  a_early: assert property (p_early) else $error("timeout too early");
  property p_float; strobe_floating [*3] |=> !watchdog_running; endproperty
  a_float: assert property (p_float) else $error("watchdog on while floating");
  property p_por; $fell(sys_rst) |-> !processor_reset_n [*8]; endproperty
  a_por: assert property (p_por) else $error("no reset at start");
  property p_off; !processor_reset_n |-> !watchdog_running; endproperty
  a_off: assert property (p_off) else $error("counting in reset");
  property p_on; $rose(watchdog_running) |-> processor_reset_n; endproperty
  a_on: assert property (p_on) else $error("counting before release");
  c_tmo: cover property ($fell(processor_reset_n) && !undervoltage);
  c_float: cover property ($rose(strobe_floating));
  c_rel: cover property ($rose(processor_reset_n));
endmodule
bind sws_supervisor sws_checker #(.TICK_LEN(TICK_LEN), .WATCHDOG_LEN(WATCHDOG_LEN), .HOLD_LEN(HOLD_LEN)) chk_u (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .undervoltage(undervoltage),
  .watchdog_strobe_input(watchdog_strobe_input), .strobe_floating(strobe_floating),
  .processor_reset_n(processor_reset_n), .watchdog_running(watchdog_running));

// *** verification/sws_proc_model.sv ***
// Processor model that services the watchdog strobe
`timescale 1ns/100ps
module sws_proc_model (
  input wire logic ref_clk, // Clock
  input wire logic processor_reset_n, // Reset in
  input wire logic [2:0] mode, // 0 low 1 fast 2 slow 3 float 4 high
  output logic strobe, // Strobe pin
  output logic floating // Strobe released
);
  logic [7:0] cnt = 8'h00;
  initial strobe = 1'h0;
  initial floating = 1'h0;
  always @(posedge ref_clk) begin
    cnt <= (cnt >= ((mode == 3'h2) ? 8'h45 : 8'h13)) ? 8'h00 : cnt + 8'h01;
    floating <= (mode == 3'h3);
    if (mode == 3'h3)
      strobe <= ~strobe; // Released pin shows no stable level
    else if (mode == 3'h4)
      strobe <= 1'h1;
    else if (mode == 3'h0 || !processor_reset_n)
      strobe <= 1'h0;
    else
      strobe <= (cnt < 8'h05);
  end
endmodule

// *** verification/tb_top.sv ***
// Testbench for the supply supervisor watchdog
`timescale 1ns/100ps
module tb_top;
  localparam int TL = 4, WL = 20, HL = 5;
  localparam int HMIN = (HL - 1) * TL + 1, HMAX = HL * TL + 6, TMIN = (WL - 1) * TL, TMAX = WL * TL + 6;
  logic ref_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic undervoltage = 1'h1;
  logic [2:0] mode = 3'h1;
  logic strobe;
  logic floating;
  logic processor_reset_n;
  logic watchdog_running;
  int error_cnt = 0;
  int checks = 0;
  int n;
  always #5 ref_clk = ~ref_clk;
  sws_supervisor #(.TICK_LEN(32'h00000004), .WATCHDOG_LEN(32'h00000014), .HOLD_LEN(32'h00000005)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .undervoltage(undervoltage), .watchdog_strobe_input(strobe),
    .strobe_floating(floating), .processor_reset_n(processor_reset_n), .watchdog_running(watchdog_running));
  sws_proc_model proc_u (.ref_clk(ref_clk), .processor_reset_n(processor_reset_n), .mode(mode),
    .strobe(strobe), .floating(floating));
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic wait_rst(input logic val, input int lim, output int cyc);
    cyc = 0;
    while (processor_reset_n !== val && cyc < lim) begin
      @(posedge ref_clk);
      #1;
      cyc++;
    end
  endtask
  task automatic t_power_up();
    undervoltage = 1'h0;
    wait_rst(1'h1, 100, n);
    chk(n >= HMIN && n < HMAX, "power-up hold");
    $display("test power_up done");
  endtask
  task automatic t_service(input logic [2:0] m);
    mode = m;
    wait_rst(1'h0, 300, n);
    chk(n == 300 && watchdog_running === 1'b1, "serviced watchdog fired");
    $display("test service done");
  endtask
  task automatic t_timeout(input logic [2:0] m);
    mode = m;
    wait_rst(1'h0, TMAX, n);
    chk(n >= TMIN - 5 && n < TMAX, "timeout length");
    wait_rst(1'h1, HMAX, n);
    chk(n >= HMIN - 1 && n < HMAX, "hold after timeout");
    $display("test timeout done");
  endtask
  task automatic t_float();
    mode = 3'h3;
    wait_rst(1'h0, 300, n);
    chk(n == 300 && watchdog_running === 1'b0, "floating strobe fired");
    mode = 3'h1;
    $display("test float done");
  endtask
  task automatic t_undervolt();
    mode = 3'h0;
    wait_rst(1'h0, 50, n);
    undervoltage = 1'h1;
    wait_rst(1'h0, 4, n);
    chk(n <= 3 && watchdog_running === 1'b0, "undervoltage reset");
    wait_rst(1'h1, 50, n);
    chk(n == 50, "released under undervoltage");
    undervoltage = 1'h0;
    wait_rst(1'h1, HMAX, n);
    chk(n >= HMIN && n < HMAX, "undervoltage hold");
    wait_rst(1'h0, TMAX, n);
    chk(n >= TMIN && n < TMAX, "counter not cleared");
    $display("test undervolt done");
  endtask
  task automatic t_mid_reset();
    mode = 3'h1;
    wait_rst(1'h1, HMAX, n);
    chk(n >= HMIN - 1 && n < HMAX, "hold before mid reset");
    sys_rst = 1'h1;
    repeat (3) @(posedge ref_clk);
    #1;
    sys_rst = 1'h0;
    chk(processor_reset_n === 1'b0 && watchdog_running === 1'b0, "outputs during reset");
    wait_rst(1'h1, 100, n);
    chk(n >= HMIN && n < HMAX, "hold after mid reset");
    $display("test mid_reset done");
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    sys_rst = 1'h0;
    t_power_up();
    t_service(3'h1);
    t_service(3'h2);
    t_timeout(3'h4);
    t_timeout(3'h0);
    t_float();
    t_undervolt();
    t_mid_reset();
    close_out();
  end
  initial begin
    #100000;
    error_cnt++;
    $display("[ERR] %0t run too long", $time);
    close_out();
  end
endmodule
